// >>> design/tmc_pkg.sv
// Constants shared by the timer/capture block and its testbench.
// Assumes a 32-bit APB bus with byte addresses and one word per register.
package tmc_pkg;

   // Bus and counter sizes
   localparam int TMC_ADDR_W = 8;
   localparam int TMC_CNT_W = 16;

   // Register byte offsets
   localparam logic [7:0] TMC_OFF_CTRL = 8'h00;
   localparam logic [7:0] TMC_OFF_CNT = 8'h04;
   localparam logic [7:0] TMC_OFF_RA = 8'h08;
   localparam logic [7:0] TMC_OFF_RB = 8'h0c;
   localparam logic [7:0] TMC_OFF_CMP = 8'h10;
   localparam logic [7:0] TMC_OFF_STAT = 8'h14;

   // Control register fields
   localparam int TMC_CTRL_ENB_BIT = 0;
   localparam int TMC_CTRL_PNDB_BIT = 1;
   localparam int TMC_CTRL_ENA_BIT = 2;
   localparam int TMC_CTRL_PNDA_BIT = 3;
   localparam int TMC_CTRL_RUN_BIT = 4;
   localparam int TMC_CTRL_MODE_LSB = 5;

   // Comparator routing fields
   localparam int TMC_CMP_EN_BIT = 0;
   localparam int TMC_CMP_SEL_BIT = 1;

   // Status fields
   localparam int TMC_STAT_PWM_BIT = 0;
   localparam int TMC_STAT_PINA_BIT = 1;
   localparam int TMC_STAT_PINB_BIT = 2;
   localparam int TMC_STAT_RLDB_BIT = 3;

   // Reset values
   localparam logic [2:0] TMC_MODE_RST = 3'h0;
   localparam logic TMC_FLAG_RST = 1'b0;
   localparam logic [15:0] TMC_CNT_RST = 16'h0000;

   // Mode codes, {bit7, bit6, bit5}
   localparam logic [2:0] TMC_MODE_PWM_TGL = 3'h5;
   localparam logic [2:0] TMC_MODE_PWM = 3'h4;
   localparam logic [2:0] TMC_MODE_EVT_RISE = 3'h0;
   localparam logic [2:0] TMC_MODE_EVT_FALL = 3'h1;
   localparam logic [2:0] TMC_MODE_CAP_RR = 3'h2;
   localparam logic [2:0] TMC_MODE_CAP_RF = 3'h6;
   localparam logic [2:0] TMC_MODE_CAP_FF = 3'h3;
   localparam logic [2:0] TMC_MODE_CAP_FF2 = 3'h7;

endpackage

// >>> design/tmc_edge_sync.sv
// Two-flop synchroniser with rise and fall pulse outputs.
// Assumes the pin is asynchronous to clk; pulses last one clk cycle.
`timescale 1ns/1ns
module tmc_edge_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Raw pin
   input wire logic pin,
   // Synchronised level and edges
   output logic level,
   output logic rise,
   output logic fall
);

   logic meta_r;
   logic sync_r;
   logic prev_r;

   // Only sync_r reads meta_r; edges look at sync_r and prev_r
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= pin;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   // One pulse per external edge [RULE22]
   assign level = sync_r;
   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;

endmodule

// >>> design/tmc_timer.sv
// Sixteen-bit timer with PWM, event count and dual capture modes.
// Assumes an APB master on pclk and asynchronous pins a, b and comparator.
// What this block does
// RULE1: Event mode counts down on pin A edges, not on the clock.
// RULE2: Event mode code picks rising or falling pin A edge.
// RULE3: Event mode underflow sets pending A; request only with enable A.
// RULE4: Event mode pin B rising edge sets pending B; gated by enable B.
// RULE5: Event mode never drives pin A as an output.
// RULE6: Capture mode counter runs every clock regardless of pins.
// RULE7: Capture copies counter into reg A or B on selected pin edges.
// RULE8: Pin A and pin B capture edges are chosen independently; code 011 gives B falling here, so A fall with B rise is not selectable.
// RULE9: Capture on A sets pending A, on B sets pending B, each gated.
// RULE10: Instance 2 may feed comparator output into capture input B.
// RULE11: Capture mode underflow sets the run bit, shares enable A.
// RULE12: Software clears the run bit when entering capture mode.
// RULE13: Software checks pending A and run bit on capture interrupt A.
// RULE14: In PWM and event modes run bit 1 starts, 0 stops counter.
// RULE15: Enables gate requests; pending flags latch regardless.
// RULE16: Codes 101 and 100 are PWM with and without pin A toggle.
// RULE17: Codes 000 and 001 select event counting mode.
// RULE18: Capture codes 010, 110, 011, 111 map to fixed edge pairs.
// RULE19: PWM first reload comes from reg A, then alternates B and A.
// RULE20: Pending flags stay set until software clears them.
// RULE21: Comparator routing only while comparator enable is set.
// RULE22: Pins are synchronised and edge detected, one event per edge.
// RULE23: Stopped PWM or event counter holds values, makes no underflow.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ns
module tmc_timer #(
   parameter int INSTANCE = 1,
   parameter int WIDTH = tmc_pkg::TMC_CNT_W
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [tmc_pkg::TMC_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Timer pins
   input wire logic timer_pin_a_in,
   output logic timer_pin_a_out,
   output logic timer_pin_a_oe,
   input wire logic timer_pin_b_in,
   input wire logic comparator_out,
   // Interrupt requests
   output logic irq_a,
   output logic irq_b
);
   import tmc_pkg::*;

   // Width must fit a data word and leave a countable range
   if (WIDTH < 2 || WIDTH > 32 || INSTANCE < 1 || INSTANCE > 3) begin : g_bad
      $error("tmc_timer: unsupported WIDTH or INSTANCE");
   end

   // Mode class decoding, used by the count and flag logic
   function automatic logic is_pwm(input logic [2:0] m);
      return m[2] & ~m[1];
   endfunction

   function automatic logic is_evt(input logic [2:0] m);
      return ~m[2] & ~m[1];
   endfunction

   function automatic logic is_cap(input logic [2:0] m);
      return m[1];
   endfunction

   // Pick one edge pulse by polarity select
   function automatic logic pick_edge(input logic r, input logic f,
                                      input logic use_fall);
      return use_fall ? f : r;
   endfunction

   // Control and data state
   logic [2:0] mode_r;
   logic run_uf_r;
   logic pend_a_r;
   logic pend_b_r;
   logic en_a_r;
   logic en_b_r;
   logic [WIDTH-1:0] cnt_r;
   logic [WIDTH-1:0] ra_r;
   logic [WIDTH-1:0] rb_r;
   logic cmp_en_r;
   logic cmp_sel_r;
   logic reload_b_r;
   logic pwm_out_r;
   logic [31:0] prdata_r;
   logic [31:0] rd_nxt;

   // Bus decode
   logic setup;
   logic access;
   logic wr;
   logic hit_ctrl;
   logic hit_cnt;
   logic hit_ra;
   logic hit_rb;
   logic hit_cmp;
   logic hit_stat;
   logic mapped;
   logic wr_ctrl;
   logic wr_cnt;
   logic wr_ra;
   logic wr_rb;
   logic wr_cmp;

   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wr = access & pwrite;
   assign hit_ctrl = paddr == TMC_OFF_CTRL;
   assign hit_cnt = paddr == TMC_OFF_CNT;
   assign hit_ra = paddr == TMC_OFF_RA;
   assign hit_rb = paddr == TMC_OFF_RB;
   assign hit_cmp = paddr == TMC_OFF_CMP;
   assign hit_stat = paddr == TMC_OFF_STAT;
   assign mapped = hit_ctrl | hit_cnt | hit_ra | hit_rb | hit_cmp | hit_stat;
   assign wr_ctrl = wr & hit_ctrl;
   assign wr_cnt = wr & hit_cnt;
   assign wr_ra = wr & hit_ra;
   assign wr_rb = wr & hit_rb;
   assign wr_cmp = wr & hit_cmp;

   // Zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;
   assign prdata = prdata_r;

   // Pin synchronisers and edge detectors
   logic pa_level;
   logic pa_rise;
   logic pa_fall;
   logic pb_level;
   logic pb_rise;
   logic pb_fall;
   logic cp_rise;
   logic cp_fall;

   tmc_edge_sync u_pin_a (
      .clk(pclk),
      .rst_n(presetn),
      .pin(timer_pin_a_in),
      .level(pa_level),
      .rise(pa_rise),
      .fall(pa_fall)
   );

   tmc_edge_sync u_pin_b (
      .clk(pclk),
      .rst_n(presetn),
      .pin(timer_pin_b_in),
      .level(pb_level),
      .rise(pb_rise),
      .fall(pb_fall)
   );

   tmc_edge_sync u_cmp (
      .clk(pclk),
      .rst_n(presetn),
      .pin(comparator_out),
      .level(),
      .rise(cp_rise),
      .fall(cp_fall)
   );

   // Event derivation
   logic cmp_route;
   logic b_rise;
   logic b_fall;
   logic pwm;
   logic evt;
   logic cap;
   logic a_trig;
   logic b_trig;
   logic tick;
   logic uflow;
   logic cap_a;
   logic cap_b;
   logic set_pa;
   logic set_pb;
   logic set_uf;

   // Comparator replaces pin B only on instance 2 [RULE10] [RULE21]
   assign cmp_route = (INSTANCE == 2) & cmp_en_r & cmp_sel_r;
   assign b_rise = cmp_route ? cp_rise : pb_rise;
   assign b_fall = cmp_route ? cp_fall : pb_fall;

   // Mode classes [RULE16] [RULE17] [RULE18]
   assign pwm = is_pwm(mode_r);
   assign evt = is_evt(mode_r);
   assign cap = is_cap(mode_r);

   // Low mode bit picks the A edge in event and capture [RULE2] [RULE8]
   assign a_trig = pick_edge(pa_rise, pa_fall, mode_r[0]);
   // B falls for codes 110, 011 and 111 [RULE8] [RULE18]
   assign b_trig = pick_edge(b_rise, b_fall, mode_r[2] | mode_r[0]);

   // Count source: clock in capture, run bit gates PWM and event
   assign tick = cap | (run_uf_r & (pwm | (evt & a_trig))); // [RULE1] [RULE6] [RULE14] [RULE23]
   assign uflow = tick & (cnt_r == '0);
   assign cap_a = cap & a_trig; // [RULE7]
   assign cap_b = cap & b_trig; // [RULE7]

   // Hardware set terms per mode
   always_comb begin
      set_pa = 1'b0;
      set_pb = 1'b0;
      if (pwm) begin
         set_pa = uflow & ~reload_b_r; // [RULE16]
         set_pb = uflow & reload_b_r; // [RULE16]
      end else if (evt) begin
         set_pa = uflow; // [RULE3]
         set_pb = b_rise; // [RULE4]
      end else begin
         set_pa = cap_a; // [RULE9]
         set_pb = cap_b; // [RULE9]
      end
   end
   assign set_uf = cap & uflow; // [RULE11]

   // Mode and enables, written by software only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= TMC_MODE_RST;
         en_a_r <= TMC_FLAG_RST;
         en_b_r <= TMC_FLAG_RST;
      end else if (wr_ctrl) begin
         mode_r <= pwdata[TMC_CTRL_MODE_LSB +: 3];
         en_a_r <= pwdata[TMC_CTRL_ENA_BIT];
         en_b_r <= pwdata[TMC_CTRL_ENB_BIT];
      end
   end

   // Sticky flags: a hardware set wins over a same-cycle clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_a_r <= TMC_FLAG_RST;
         pend_b_r <= TMC_FLAG_RST;
         run_uf_r <= TMC_FLAG_RST;
      end else begin
         pend_a_r <= set_pa |
            (wr_ctrl ? pwdata[TMC_CTRL_PNDA_BIT] : pend_a_r); // [RULE20]
         pend_b_r <= set_pb |
            (wr_ctrl ? pwdata[TMC_CTRL_PNDB_BIT] : pend_b_r); // [RULE20]
         run_uf_r <= set_uf |
            (wr_ctrl ? pwdata[TMC_CTRL_RUN_BIT] : run_uf_r); // [RULE11] [RULE14]
      end
   end

   // Counter: software write wins, else reload or count down
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= WIDTH'(TMC_CNT_RST);
      end else if (wr_cnt) begin
         cnt_r <= pwdata[WIDTH-1:0];
      end else if (uflow & ~cap) begin
         cnt_r <= (pwm & reload_b_r) ? rb_r : ra_r; // [RULE19]
      end else if (tick) begin
         cnt_r <= cnt_r - WIDTH'(1); // [RULE1] [RULE6]
      end
   end

   // Reload order restarts from reg A whenever a control write changes the mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reload_b_r <= TMC_FLAG_RST;
      end else if (wr_ctrl & (pwdata[TMC_CTRL_MODE_LSB +: 3] != mode_r)) begin
         reload_b_r <= 1'b0;
      end else if (pwm & uflow) begin
         reload_b_r <= ~reload_b_r; // [RULE19]
      end
   end

   // Reload/capture registers; a bus write wins over a capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ra_r <= WIDTH'(TMC_CNT_RST);
         rb_r <= WIDTH'(TMC_CNT_RST);
      end else begin
         if (wr_ra) begin
            ra_r <= pwdata[WIDTH-1:0];
         end else if (cap_a) begin
            ra_r <= cnt_r; // [RULE7]
         end
         if (wr_rb) begin
            rb_r <= pwdata[WIDTH-1:0];
         end else if (cap_b) begin
            rb_r <= cnt_r; // [RULE7]
         end
      end
   end

   // Comparator routing controls
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_en_r <= TMC_FLAG_RST;
         cmp_sel_r <= TMC_FLAG_RST;
      end else if (wr_cmp) begin
         cmp_en_r <= pwdata[TMC_CMP_EN_BIT];
         cmp_sel_r <= pwdata[TMC_CMP_SEL_BIT];
      end
   end

   // PWM waveform toggles on every underflow in the toggle mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_out_r <= TMC_FLAG_RST;
      end else if ((mode_r == TMC_MODE_PWM_TGL) & uflow) begin
         pwm_out_r <= ~pwm_out_r; // [RULE16]
      end
   end

   // Pin A drives only in toggle PWM; it is an input otherwise [RULE5]
   assign timer_pin_a_out = pwm_out_r;
   assign timer_pin_a_oe = (mode_r == TMC_MODE_PWM_TGL);

   // Requests: capture underflow shares enable A [RULE11] [RULE15]
   assign irq_a = en_a_r & (pend_a_r | (cap & run_uf_r)); // [RULE3] [RULE9]
   assign irq_b = en_b_r & pend_b_r; // [RULE4] [RULE9] [RULE15]

   // Read mux, sampled in the setup cycle so data comes from a flop
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_nxt[TMC_CTRL_MODE_LSB +: 3] = mode_r;
         rd_nxt[TMC_CTRL_RUN_BIT] = run_uf_r;
         rd_nxt[TMC_CTRL_PNDA_BIT] = pend_a_r;
         rd_nxt[TMC_CTRL_ENA_BIT] = en_a_r;
         rd_nxt[TMC_CTRL_PNDB_BIT] = pend_b_r;
         rd_nxt[TMC_CTRL_ENB_BIT] = en_b_r;
      end else if (hit_cnt) begin
         rd_nxt[WIDTH-1:0] = cnt_r;
      end else if (hit_ra) begin
         rd_nxt[WIDTH-1:0] = ra_r;
      end else if (hit_rb) begin
         rd_nxt[WIDTH-1:0] = rb_r;
      end else if (hit_cmp) begin
         rd_nxt[TMC_CMP_EN_BIT] = cmp_en_r;
         rd_nxt[TMC_CMP_SEL_BIT] = cmp_sel_r;
      end else if (hit_stat) begin
         rd_nxt[TMC_STAT_PWM_BIT] = pwm_out_r;
         rd_nxt[TMC_STAT_PINA_BIT] = pa_level;
         rd_nxt[TMC_STAT_PINB_BIT] = pb_level;
         rd_nxt[TMC_STAT_RLDB_BIT] = reload_b_r;
      end
   end

   // Counter may move between setup and access; the setup value is read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup & ~pwrite) begin
         prdata_r <= rd_nxt;
      end
   end

   // Checks of the block's own behaviour
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_cap_a_edge;
      cap_a && !wr_ra;
   endsequence

   sequence s_cap_a_done;
      ra_r == $past(cnt_r) && pend_a_r;
   endsequence

   a_event_count_down: assert property ( // [RULE1]
      evt && run_uf_r && a_trig && cnt_r != '0 && !wr_cnt
      |=> cnt_r == $past(cnt_r) - WIDTH'(1))
      else $error("event edge did not decrement counter");

   a_event_wrong_edge: assert property ( // [RULE2]
      mode_r == TMC_MODE_EVT_RISE && pa_fall && !wr_cnt
      |=> $stable(cnt_r))
      else $error("counter moved on unselected pin edge");

   a_event_uflow_pend: assert property ( // [RULE3]
      evt && uflow |=> pend_a_r && (irq_a == en_a_r))
      else $error("event underflow did not latch pending A");

   a_event_pinb_pend: assert property ( // [RULE4]
      evt && b_rise |=> pend_b_r)
      else $error("pin B rise lost in event mode");

   a_event_no_drive: assert property ( // [RULE5]
      evt |-> !timer_pin_a_oe)
      else $error("pin A driven in event mode");

   a_capture_free_run: assert property ( // [RULE6]
      cap && !wr_cnt |=> cnt_r == $past(cnt_r) - WIDTH'(1))
      else $error("capture counter not running");

   a_capture_reg_a: assert property ( // [RULE7] [RULE9]
      s_cap_a_edge |=> s_cap_a_done)
      else $error("capture A value or flag wrong");

   a_capture_uflow: assert property ( // [RULE11]
      cap && uflow |=> run_uf_r ##0 (irq_a || !en_a_r))
      else $error("capture underflow not flagged");

   a_irq_gate: assert property ( // [RULE15]
      !en_b_r |-> !irq_b)
      else $error("request B raised while disabled");

   a_pend_sticky: assert property ( // [RULE20]
      pend_a_r && !wr_ctrl |=> pend_a_r)
      else $error("pending A dropped without software");

   a_stop_hold: assert property ( // [RULE23]
      !cap && !run_uf_r && !wr_cnt && !wr_ctrl
      |=> $stable(cnt_r) && !uflow)
      else $error("stopped counter changed");

   a_pwm_alternate: assert property ( // [RULE19]
      pwm && uflow && !reload_b_r && !wr_cnt && !wr_ctrl
      |=> reload_b_r && cnt_r == $past(ra_r))
      else $error("first PWM reload not from register A");

endmodule

// >>> test/tmc_pin_model.sv
// Far-side model: pin A, pin B and the comparator level.
// Assumes a free-running pclk; each level holds for at least five cycles.
`timescale 1ns/1ns
module tmc_pin_model (
   // Clock
   input wire logic pclk,
   // Driven levels
   output logic pin_a,
   output logic pin_b,
   output logic cmp
);
   // Pins rest low, as the synchronisers do at reset
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b0;
      cmp = 1'b0;
   end

   // Change one level after an edge, then hold it for sync plus edge detect
   task automatic drive(input int sel, input logic val, input int extra);
      @(posedge pclk);
      case (sel)
         0: pin_a <= val;
         1: pin_b <= val;
         default: cmp <= val;
      endcase
      repeat (5 + extra) @(posedge pclk); // Short pulses may be lost
   endtask
endmodule

// >>> test/multimode_timer_capture_counter_tb.sv
// Self-checking bench for the timer block, instance 2, over APB.
// Assumes the pin model above drives pins A, B and the comparator.
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
$display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module multimode_timer_capture_counter_tb;
   import tmc_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, q;
   logic pready, pslverr, err, pa_out, pa_oe, pa_mdl, pa_wire, pb, cmp;
   logic irq_a, irq_b;
   logic [15:0] rnd = 16'h0025;
   logic [15:0] k, ra, c1, c2;
   logic [2:0] m;
   logic [2:0] caps [4] = '{3'h2, 3'h6, 3'h3, 3'h7};
   int num_errors = 0;
   int checked = 0;
   int n;

   // Clock, 50 ns period
   always #25 pclk = ~pclk;

   // Pin A wire: the timer wins while it drives
   assign pa_wire = pa_oe ? pa_out : pa_mdl;

   tmc_pin_model i_tmc_pin_model (.pclk(pclk), .pin_a(pa_mdl), .pin_b(pb),
      .cmp(cmp));
   tmc_timer #(.INSTANCE(2)) i_tmc_timer (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_pin_a_in(pa_wire), .timer_pin_a_out(pa_out),
      .timer_pin_a_oe(pa_oe), .timer_pin_b_in(pb), .comparator_out(cmp),
      .irq_a(irq_a), .irq_b(irq_b));

   // Pseudo-random source, fixed start
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Control word: mode, then run, pend A, en A, pend B, en B
   function automatic logic [31:0] ctrl_word(input logic [2:0] md,
      input logic [4:0] f);
      return {24'h0, md, f};
   endfunction

   task automatic print_verdict();
      if (num_errors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // One APB transfer; holds everything until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20) begin
         num_errors++;
         print_verdict();
      end
   endtask

   // Pin change with a random extra hold, so the far side is sometimes slow
   task automatic pin(input int sel, input logic val);
      i_tmc_pin_model.drive(sel, val, int'(rnd[1:0]));
      rnd = lfsr_next(rnd);
   endtask

   // Main sequence
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, TMC_OFF_CTRL, 0);
      `CHK(q, 32'h0)
      apb(0, TMC_OFF_CNT, 0);
      `CHK(q, 32'h0)
      apb(0, 8'h40, 0);
      `CHK({err, q}, 33'h100000000)
      // Event counting: rising code, then falling code
      for (int i = 0; i < 2; i++) begin
         m = 3'(i);
         k = 16'(rnd[1:0]) + 16'h2;
         ra = rnd | 16'h0010;
         rnd = lfsr_next(rnd);
         apb(1, TMC_OFF_CNT, {16'h0, k});
         apb(1, TMC_OFF_RA, {16'h0, ra});
         apb(1, TMC_OFF_CTRL, ctrl_word(m, {2'b10, !m[0], 2'b01}));
         pin(0, 1'b1);
         apb(0, TMC_OFF_CNT, 0);
         `CHK(q[15:0], k - 16'(!m[0]))
         pin(0, 1'b0);
         apb(0, TMC_OFF_CNT, 0);
         `CHK(q[15:0], k - 16'h1)
         repeat (k) begin
            pin(0, 1'b1);
            pin(0, 1'b0);
         end
         apb(0, TMC_OFF_CTRL, 0);
         `CHK({q[3], irq_a}, {1'b1, !m[0]})
         apb(0, TMC_OFF_CNT, 0);
         `CHK(q[15:0], ra)
         `CHK(pa_oe, 1'b0)
         pin(1, 1'b1);
         pin(1, 1'b0);
         apb(0, TMC_OFF_CTRL, 0);
         `CHK({q[3], q[1], irq_b}, 3'h7)
         // Stopped: pin A edges must not move the count
         apb(1, TMC_OFF_CTRL, ctrl_word(m, 5'b00101));
         repeat (2) begin
            pin(0, 1'b1);
            pin(0, 1'b0);
         end
         apb(0, TMC_OFF_CNT, 0);
         `CHK(q[15:0], ra)
         apb(0, TMC_OFF_CTRL, 0);
         `CHK(q[3], 1'b0)
      end
      // Capture codes: rising edges first, then falling edges
      apb(1, TMC_OFF_CNT, 32'hffff);
      for (int i = 0; i < 4; i++) begin
         m = caps[i];
         apb(1, TMC_OFF_CTRL, ctrl_word(m, 5'b00101));
         pin(0, 1'b1);
         pin(1, 1'b1);
         apb(0, TMC_OFF_CTRL, 0);
         `CHK({q[3], q[1]}, {!m[0], m == 3'h2})
         `CHK({irq_a, irq_b}, {!m[0], m == 3'h2})
         apb(1, TMC_OFF_CTRL, ctrl_word(m, 5'b00101));
         apb(0, TMC_OFF_CNT, 0);
         c1 = q[15:0];
         pin(0, 1'b0);
         pin(1, 1'b0);
         apb(0, TMC_OFF_CNT, 0);
         c2 = q[15:0];
         `CHK(c1 !== c2, 1'b1)
         apb(0, TMC_OFF_CTRL, 0);
         `CHK({q[3], q[1]}, {m[0], m != 3'h2})
         apb(0, TMC_OFF_RA, 0);
         if (m[0]) `CHK(c1 - q[15:0] < c1 - c2, 1'b1)
      end
      // Capture underflow lands in the run bit and shares request A
      apb(1, TMC_OFF_CTRL, ctrl_word(TMC_MODE_CAP_RR, 5'b00100));
      apb(1, TMC_OFF_CNT, 32'h3);
      for (n = 0; n < 20 && irq_a !== 1'b1; n++) @(posedge pclk);
      // A request that never comes ends the run as a failure
      if (irq_a !== 1'b1) begin
         num_errors++;
         print_verdict();
      end
      apb(0, TMC_OFF_CTRL, 0);
      `CHK({q[4], q[3], irq_a}, 3'h5)
      // Comparator feeds capture B only while enabled
      apb(1, TMC_OFF_CMP, 32'h3);
      apb(1, TMC_OFF_CTRL, ctrl_word(TMC_MODE_CAP_RR, 5'b00001));
      pin(2, 1'b1);
      apb(0, TMC_OFF_CTRL, 0);
      `CHK({q[1], irq_b}, 2'h3)
      apb(1, TMC_OFF_CMP, 32'h2);
      apb(1, TMC_OFF_CTRL, ctrl_word(TMC_MODE_CAP_RR, 5'b00001));
      pin(2, 1'b0);
      pin(2, 1'b1);
      apb(0, TMC_OFF_CTRL, 0);
      `CHK(q[1], 1'b0)
      pin(1, 1'b1);
      apb(0, TMC_OFF_CTRL, 0);
      `CHK(q[1], 1'b1)
      // PWM: mode set while stopped so the first reload is from A
      apb(1, TMC_OFF_RA, 32'h14);
      apb(1, TMC_OFF_RB, 32'h1e);
      apb(1, TMC_OFF_CTRL, ctrl_word(TMC_MODE_PWM_TGL, 5'b00101));
      apb(1, TMC_OFF_CNT, 32'h0);
      apb(1, TMC_OFF_CTRL, ctrl_word(TMC_MODE_PWM_TGL, 5'b10101));
      apb(0, TMC_OFF_CTRL, 0);
      `CHK({q[3], q[1], pa_oe}, 3'h5)
      `CHK(pa_out, 1'b1)
      // Status: next reload from B, both pins high, waveform high
      apb(0, TMC_OFF_STAT, 0);
      `CHK(q[3:0], 4'hf)
      for (n = 0; n < 40 && irq_b !== 1'b1; n++) @(posedge pclk);
      if (irq_b !== 1'b1) begin
         num_errors++;
         print_verdict();
      end
      `CHK(irq_b, 1'b1)
      `CHK(pa_out, 1'b0)
      apb(1, TMC_OFF_CTRL, ctrl_word(TMC_MODE_PWM, 5'b10000));
      @(posedge pclk);
      `CHK(pa_oe, 1'b0)
      print_verdict();
   end
endmodule
